/* logic/rx_video_pass_qualifier.v */
// How it works
// - Five interrupt sources per transmit port.
// - Status bits set regardless of enable.
// - On error, flag it, stop frame.
// - After recovery, send new frame start first.
// - Discard video until qualified, when enabled.
// - Qualify after zero to three valid frames.
// - Threshold zero qualifies at lock.
// - Line length change flagged, count restarts.
// - Line count change restarts count.
// - Parity error clears qualified and count.
// - After parity error, qualify one frame early.
// - Cut-off ends frame without frame end.
// - Cut-off may follow any line count.
// - Cut-off persists through next valid frame.
`timescale 1ns/100ps
`include "rx_video_pass_qualifier_regs.vh"
module rx_video_pass_qualifier (
  input  wire        SYS_CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [9:0]  PADDR,
  input  wire [31:0] PWDATA,
  input  wire [3:0]  PSTRB,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        LINK_CLK,
  input  wire        LINK_LOCK,
  input  wire        LINK_FRAME,
  input  wire        LINK_LINE,
  input  wire [7:0]  LINK_DATA,
  input  wire        LINK_PARITY_ERR,
  input  wire        STREAMS_SYNCED,
  input  wire        STREAM_SYNC_LOST,
  input  wire        RX_PORT_IRQ,
  output reg         OUT_SOF,
  output reg         OUT_EOF,
  output reg         OUT_VALID,
  output reg  [7:0]  OUT_DATA,
  output reg         PASS,
  output reg         TX_IRQ
);

  //////////////////////////////////////////////////////////////////////////////
  // Link inputs come from another domain and pass two flops first.
  wire [12:0] sync_w;
  wire        lclk_s;
  wire        lock_s;
  wire        frame_s;
  wire        line_s;
  wire        par_s;
  wire [7:0]  data_s;

  bit_sync2 #(
    .W(13)
  ) u_sync (
    .clk (SYS_CLK),
    .rst (RST),
    .din ({LINK_CLK, LINK_LOCK, LINK_FRAME, LINK_LINE, LINK_PARITY_ERR, LINK_DATA}),
    .dout(sync_w)
  );

  assign lclk_s  = sync_w[12];
  assign lock_s  = sync_w[11];
  assign frame_s = sync_w[10];
  assign line_s  = sync_w[9];
  assign par_s   = sync_w[8];
  assign data_s  = sync_w[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Link clock edge finding and sampling of the stream on its rising edge.
  reg       lclk_q;
  reg       frame_q;
  reg       line_q;
  reg       par_q;
  reg [7:0] data_q;
  reg       edge_q;
  wire      lclk_rise;

  assign lclk_rise = lclk_s && !lclk_q;

  // Captures the stream levels at each link clock rising edge.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      lclk_q  <= 1'b0;
      frame_q <= 1'b0;
      line_q  <= 1'b0;
      par_q   <= 1'b0;
      data_q  <= 8'h00;
      edge_q  <= 1'b0;
    end else begin
      lclk_q <= lclk_s;
      edge_q <= lclk_rise;
      if (lclk_rise) begin
        frame_q <= frame_s;
        line_q  <= line_s;
        par_q   <= par_s;
        data_q  <= data_s;
      end
    end
  end

  // Stream events, one cycle wide, derived from the sampled levels.
  reg  prev_frame_q;
  reg  prev_line_q;
  reg  prev_par_q;
  wire frame_start;
  wire frame_end;
  wire line_end;
  wire byte_stb;
  wire par_err;

  assign frame_start = edge_q && frame_q && !prev_frame_q;
  assign frame_end   = edge_q && !frame_q && prev_frame_q;
  assign line_end    = edge_q && !line_q && prev_line_q;
  assign byte_stb    = edge_q && frame_q && line_q;
  assign par_err     = edge_q && par_q && !prev_par_q;

  // Keeps the levels of the previous link edge.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      prev_frame_q <= 1'b0;
      prev_line_q  <= 1'b0;
      prev_par_q   <= 1'b0;
    end else if (edge_q) begin
      prev_frame_q <= frame_q;
      prev_line_q  <= line_q;
      prev_par_q   <= par_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file.
  reg [7:0] int_en_q;
  reg [7:0] qual_ctrl_q;
  reg [7:0] cutoff_cfg_q;
  reg [`INT_BITS-1:0] int_st_q;
  reg [`INT_BITS-1:0] int_set;
  reg [1:0] count_q;
  reg       cut_q;

  wire [1:0] thresh;
  wire       qc_discard;
  wire       qc_line_size;
  wire       qc_line_cnt;
  wire       qc_parity;
  wire       access;
  wire       wr_en;
  wire       rd_en;
  wire [7:0] idx;

  assign thresh       = qual_ctrl_q[`QC_THRESH_MSB:`QC_THRESH_LSB];
  assign qc_discard   = qual_ctrl_q[`QC_DISCARD];
  assign qc_line_size = qual_ctrl_q[`QC_LINE_SIZE];
  assign qc_line_cnt  = qual_ctrl_q[`QC_LINE_CNT];
  assign qc_parity    = qual_ctrl_q[`QC_PARITY];
  assign idx          = PADDR[9:2];
  assign access       = PSEL && PENABLE;
  assign wr_en        = access && PREADY && PWRITE && PSTRB[0];
  assign rd_en        = access && !PREADY && !PWRITE;

  // APB answer: ready comes one cycle into the access phase, data with it.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= access && !PREADY;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
      if (access && !PREADY) begin
        case (idx)
          `IDX_TX_INT_ENABLE: PRDATA <= {24'h000000, int_en_q};
          `IDX_TX_INT_STATUS: PRDATA <= {27'h0000000, int_st_q};
          `IDX_RX_QUAL_CTRL:  PRDATA <= {24'h000000, qual_ctrl_q};
          `IDX_RX_CUTOFF_CFG: PRDATA <= {24'h000000, cutoff_cfg_q};
          `IDX_RX_STATUS:     PRDATA <= {27'h0000000, count_q, cut_q, PASS, lock_s};
          default:            PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  // Writable control registers; a write lands at the edge with pready high.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      int_en_q     <= `RST_TX_INT_ENABLE;
      qual_ctrl_q  <= `RST_RX_QUAL_CTRL;
      cutoff_cfg_q <= `RST_RX_CUTOFF_CFG;
    end else if (wr_en) begin
      case (idx)
        `IDX_TX_INT_ENABLE: int_en_q     <= PWDATA[7:0];
        `IDX_RX_QUAL_CTRL:  qual_ctrl_q  <= PWDATA[7:0];
        `IDX_RX_CUTOFF_CFG: cutoff_cfg_q <= PWDATA[7:0];
        default:            int_en_q     <= int_en_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line length and line count measurement.
  wire len_chg;
  wire cnt_chg;

  frame_size_checker u_check (
    .clk      (SYS_CLK),
    .rst      (RST),
    .clear    (!lock_s),
    .byte_stb (byte_stb),
    .line_end (line_end),
    .frame_end(frame_end),
    .len_chg  (len_chg),
    .cnt_chg  (cnt_chg)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Frame qualification.
  reg  bad_frame_q;
  reg  par_early_q;
  wire size_bad;
  wire lines_bad;
  wire par_bad;
  wire [1:0] need;
  wire pass_d;

  assign size_bad  = qc_line_size && len_chg;
  assign lines_bad = qc_line_cnt && cnt_chg;
  assign par_bad   = qc_parity && par_err;
  // One frame less is needed while recovering from a parity error.
  assign need      = (par_early_q && thresh != 2'd0) ? thresh - 2'd1 : thresh;
  // Threshold zero qualifies as soon as lock is reported.
  assign pass_d    = lock_s && (count_q >= need) && !par_bad;

  // Counts valid frames; any enabled size change or parity error restarts it.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      count_q     <= 2'd0;
      bad_frame_q <= 1'b0;
      par_early_q <= 1'b0;
      PASS        <= 1'b0;
    end else if (!lock_s) begin
      count_q     <= 2'd0;
      bad_frame_q <= 1'b0;
      par_early_q <= 1'b0;
      PASS        <= 1'b0;
    end else begin
      PASS <= pass_d && !(size_bad || lines_bad);
      if (par_bad) begin
        count_q     <= 2'd0;
        par_early_q <= 1'b1;
        bad_frame_q <= 1'b1;
      end else if (size_bad || lines_bad) begin
        count_q     <= 2'd0;
        bad_frame_q <= 1'b1;
      end else if (frame_end) begin
        if (!bad_frame_q && count_q < thresh) begin
          count_q <= count_q + 2'd1;
        end
        bad_frame_q <= 1'b0;
      end else if (frame_start) begin
        bad_frame_q <= 1'b0;
      end
      if (!par_bad && count_q >= thresh) begin
        par_early_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Forwarding with discard and cut-off.
  reg  fwd_q;
  reg  clean_q;
  wire cut_now;
  wire allow;

  assign cut_now = (cutoff_cfg_q[`CO_LINE_SIZE] && len_chg) ||
                   (cutoff_cfg_q[`CO_LINE_CNT] && cnt_chg) ||
                   (cutoff_cfg_q[`CO_PARITY] && par_err);
  // Video is dropped until qualified when discard is enabled.
  assign allow   = !(qc_discard && !pass_d) && !cut_q;

  // Tracks whether the current frame is forwarded and the cut-off state.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      fwd_q   <= 1'b0;
      cut_q   <= 1'b0;
      clean_q <= 1'b0;
    end else begin
      if (cut_now && frame_q) begin
        fwd_q   <= 1'b0;
        cut_q   <= 1'b1;
        clean_q <= 1'b0;
      end else if (frame_start) begin
        fwd_q   <= allow;
        clean_q <= 1'b1;
      end else if (frame_end) begin
        fwd_q <= 1'b0;
        if (clean_q) begin
          cut_q <= 1'b0;
        end
      end else if (qc_discard && !pass_d) begin
        fwd_q <= 1'b0;
      end
    end
  end

  // Output stream; frame end is withheld when the frame was cut.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      OUT_SOF   <= 1'b0;
      OUT_EOF   <= 1'b0;
      OUT_VALID <= 1'b0;
      OUT_DATA  <= 8'h00;
    end else begin
      OUT_SOF   <= frame_start && allow && !cut_now;
      OUT_EOF   <= frame_end && fwd_q && !cut_now;
      OUT_VALID <= byte_stb && !cut_now && (frame_start ? allow : fwd_q);
      OUT_DATA  <= data_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit port interrupt status and output.
  reg pass_prev_q;
  reg synced_prev_q;
  reg lost_prev_q;
  reg rxirq_prev_q;

  // Event detection for each interrupt source.
  always @* begin
    int_set                 = {`INT_BITS{1'b0}};
    int_set[`INT_PASS_ON]   = PASS && !pass_prev_q;
    int_set[`INT_SYNCED]    = STREAMS_SYNCED && !synced_prev_q;
    int_set[`INT_PASS_OFF]  = !PASS && pass_prev_q;
    int_set[`INT_SYNC_LOST] = STREAM_SYNC_LOST && !lost_prev_q;
    int_set[`INT_RX_PORT]   = RX_PORT_IRQ && !rxirq_prev_q;
  end

  // Sticky status, set regardless of enable, cleared by reading it.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pass_prev_q   <= 1'b0;
      synced_prev_q <= 1'b0;
      lost_prev_q   <= 1'b0;
      rxirq_prev_q  <= 1'b0;
      int_st_q      <= {`INT_BITS{1'b0}};
      TX_IRQ        <= 1'b0;
    end else begin
      pass_prev_q   <= PASS;
      synced_prev_q <= STREAMS_SYNCED;
      lost_prev_q   <= STREAM_SYNC_LOST;
      rxirq_prev_q  <= RX_PORT_IRQ;
      if (rd_en && idx == `IDX_TX_INT_STATUS) begin
        int_st_q <= int_set;
      end else begin
        int_st_q <= int_st_q | int_set;
      end
      TX_IRQ <= |(int_st_q & int_en_q[`INT_BITS-1:0]);
    end
  end

endmodule

/* pkg/rx_video_pass_qualifier_regs.vh */
`ifndef RX_VIDEO_PASS_QUALIFIER_REGS_VH
`define RX_VIDEO_PASS_QUALIFIER_REGS_VH

// Register indexes; the byte address on APB is four times the index.
`define IDX_TX_INT_ENABLE   8'h36
`define IDX_TX_INT_STATUS   8'h37
`define IDX_RX_QUAL_CTRL    8'h38
`define IDX_RX_CUTOFF_CFG   8'h39
`define IDX_RX_STATUS       8'h3A

// Reset values.
`define RST_TX_INT_ENABLE   8'h00
`define RST_RX_QUAL_CTRL    8'h00
`define RST_RX_CUTOFF_CFG   8'h00

// Interrupt source bit positions in enable and status.
`define INT_PASS_ON         0
`define INT_SYNCED          1
`define INT_PASS_OFF        2
`define INT_SYNC_LOST       3
`define INT_RX_PORT         4
`define INT_BITS            5

// Qualify control fields.
`define QC_THRESH_LSB       0
`define QC_THRESH_MSB       1
`define QC_DISCARD          2
`define QC_LINE_SIZE        3
`define QC_LINE_CNT         4
`define QC_PARITY           5

// Cut-off configuration fields.
`define CO_LINE_SIZE        0
`define CO_LINE_CNT         1
`define CO_PARITY           2

// Receive status fields.
`define ST_LOCK             0
`define ST_PASS             1
`define ST_CUTOFF           2
`define ST_COUNT_LSB        3
`define ST_COUNT_MSB        4

// Measurement counter width.
`define MEAS_W              16

`endif

/* logic/bit_sync2.v */
`timescale 1ns/100ps
module bit_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  //////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg stab_q;
      // Two flops per bit; only the second flop reads the first.
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= din[i];
          stab_q <= meta_q;
        end
      end
      assign dout[i] = stab_q;
    end
  endgenerate

endmodule

/* logic/frame_size_checker.v */
`timescale 1ns/100ps
`include "rx_video_pass_qualifier_regs.vh"
module frame_size_checker (
  input  wire clk,
  input  wire rst,
  input  wire clear,
  input  wire byte_stb,
  input  wire line_end,
  input  wire frame_end,
  output reg  len_chg,
  output reg  cnt_chg
);

  //////////////////////////////////////////////////////////////////////////////
  reg [`MEAS_W-1:0] len_q;
  reg [`MEAS_W-1:0] ref_len_q;
  reg               ref_len_ok_q;
  reg [`MEAS_W-1:0] lines_q;
  reg [`MEAS_W-1:0] ref_lines_q;
  reg               ref_lines_ok_q;

  // Measures bytes per line and lines per frame against the last seen values.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      len_q          <= {`MEAS_W{1'b0}};
      ref_len_q      <= {`MEAS_W{1'b0}};
      ref_len_ok_q   <= 1'b0;
      lines_q        <= {`MEAS_W{1'b0}};
      ref_lines_q    <= {`MEAS_W{1'b0}};
      ref_lines_ok_q <= 1'b0;
      len_chg        <= 1'b0;
      cnt_chg        <= 1'b0;
    end else if (clear) begin
      len_q          <= {`MEAS_W{1'b0}};
      ref_len_ok_q   <= 1'b0;
      lines_q        <= {`MEAS_W{1'b0}};
      ref_lines_ok_q <= 1'b0;
      len_chg        <= 1'b0;
      cnt_chg        <= 1'b0;
    end else begin
      len_chg <= 1'b0;
      cnt_chg <= 1'b0;
      if (byte_stb) begin
        len_q <= len_q + 1'b1;
      end
      if (line_end) begin
        // A line differing from the previous one, in or across frames.
        len_chg      <= ref_len_ok_q && (len_q != ref_len_q);
        ref_len_q    <= len_q;
        ref_len_ok_q <= 1'b1;
        len_q        <= {`MEAS_W{1'b0}};
        lines_q      <= lines_q + 1'b1;
      end
      if (frame_end) begin
        cnt_chg        <= ref_lines_ok_q && (lines_q != ref_lines_q);
        ref_lines_q    <= lines_q;
        ref_lines_ok_q <= 1'b1;
        lines_q        <= {`MEAS_W{1'b0}};
      end
    end
  end

endmodule

/* tb/rx_video_pass_qualifier_chk.sv */
`timescale 1ns/100ps
module rx_pass_chk (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        LINK_LOCK,
  input wire logic        OUT_SOF,
  input wire logic        OUT_EOF,
  input wire logic        OUT_VALID,
  input wire logic        PASS,
  input wire logic        TX_IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  // Bus answers come one wait state after the access starts.
  chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("Ready held too long.");
  chk_ready_wait: assert property (PSEL && PENABLE && !PREADY && !$past(PENABLE) |=> PREADY)
    else $error("Ready not one wait state late.");
  chk_ready_cause: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("Ready without access.");
  chk_err_ready: assert property (PSLVERR |-> PREADY) else $error("Error without ready.");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h00000000)
    else $error("Read data outside answer.");
  // Video output framing, pass against lock, and interrupt clearing.
  chk_sof_byte: assert property (OUT_SOF |-> OUT_VALID) else $error("Start without byte.");
  chk_valid_pulse: assert property (OUT_VALID |=> !OUT_VALID) else $error("Byte held.");
  chk_eof_alone: assert property (OUT_EOF |=> !OUT_EOF && !OUT_VALID) else $error("Bad end.");
  chk_pass_lock: assert property (!LINK_LOCK [*8] |-> !PASS) else $error("Pass without lock.");
  chk_irq_clear: assert property ($fell(TX_IRQ) |-> $past(PREADY) || $past(PREADY, 2))
    else $error("Interrupt dropped without access.");
  cover property (OUT_EOF);
  cover property ($rose(PASS));
  cover property (PSLVERR);
endmodule
bind rx_video_pass_qualifier rx_pass_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_LOCK(LINK_LOCK),
  .OUT_SOF(OUT_SOF), .OUT_EOF(OUT_EOF), .OUT_VALID(OUT_VALID), .PASS(PASS), .TX_IRQ(TX_IRQ));

/* tb/csi2_sink_model.sv */
`timescale 1ns/100ps
module csi2_sink_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic sof,
  input wire logic eof,
  input wire logic valid,
  input wire logic [7:0] data,
  output int       n_sof,
  output int       n_eof,
  output int       n_byte,
  output int       n_rep,
  output int       n_sum
);
  logic in_frame;
  // Counts frames and bytes; a start inside an open frame marks it suspect.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      n_sof <= 0;
      n_eof <= 0;
      n_byte <= 0;
      n_rep <= 0;
      n_sum <= 0;
      in_frame <= 1'b0;
    end else begin
      if (sof) begin
        n_sof <= n_sof + 1;
        n_rep <= n_rep + (in_frame ? 1 : 0);
      end
      if (eof) n_eof <= n_eof + 1;
      if (sof || eof) in_frame <= sof;
      if (valid) n_byte <= n_byte + 1;
      if (valid) n_sum <= n_sum + int'(data);
    end
  end
endmodule

/* tb/rx_video_pass_qualifier_tb.sv */
`timescale 1ns/100ps
`include "rx_video_pass_qualifier_regs.vh"
module rx_video_pass_qualifier_tb;
  logic        clk, rst, lclk, psel, penable, pwrite, pready, pslverr, err;
  logic        lock, lframe, lline, perr, synced, slost, rxirq, osof, oeof, ovalid, pass, irq;
  logic [9:0]  paddr;
  logic [7:0]  ldata, odata;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail, n_tests, n_sof, n_eof, n_byte, n_rep, n_sum, s0, e0, b0, d0;
  rx_video_pass_qualifier dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK_CLK(lclk), .LINK_LOCK(lock), .LINK_FRAME(lframe),
    .LINK_LINE(lline), .LINK_DATA(ldata), .LINK_PARITY_ERR(perr), .STREAMS_SYNCED(synced),
    .STREAM_SYNC_LOST(slost), .RX_PORT_IRQ(rxirq), .OUT_SOF(osof), .OUT_EOF(oeof),
    .OUT_VALID(ovalid), .OUT_DATA(odata), .PASS(pass), .TX_IRQ(irq));
  csi2_sink_model sink (.clk(clk), .rst(rst), .sof(osof), .eof(oeof), .valid(ovalid),
    .data(odata), .n_sof(n_sof), .n_eof(n_eof), .n_byte(n_byte), .n_rep(n_rep),
    .n_sum(n_sum));
  // System and link clocks with unrelated phase.
  always #5 clk = ~clk;
  always #62.5 lclk <= ~lclk;
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus transfer, held until ready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
    rd = prdata;
    err = pslverr;
    if (i == 20) begin
      n_fail++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] msk, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd & msk, exp);
  endtask
  // Sends one link frame; the parity error line rises from line pl on.
  task automatic frame(input int nl, input int l0, input int lx, input int pl);
    int l, b;
    s0 = n_sof;
    e0 = n_eof;
    b0 = n_byte;
    d0 = n_sum;
    for (l = 0; l < nl; l++) begin
      for (b = 0; b < ((l == nl - 1) ? lx : l0); b++) begin
        @(negedge lclk);
        lframe <= 1'b1;
        lline <= 1'b1;
        perr <= (l >= pl);
        ldata <= 8'(b + 1);
      end
      @(negedge lclk);
      lline <= 1'b0;
    end
    @(negedge lclk);
    lframe <= 1'b0;
    perr <= 1'b0;
    repeat (4) @(negedge lclk);
  endtask
  task automatic cnt(input int ds, input int de, input int db);
    chk(n_sof - s0, ds);
    chk(n_eof - e0, de);
    chk(n_byte - b0, db);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] idx [3] = '{`IDX_TX_INT_ENABLE, `IDX_RX_QUAL_CTRL, `IDX_RX_CUTOFF_CFG};
    logic [31:0] msk [3] = '{32'hFF, 32'hFF, 32'hFF};
    for (int k = 0; k < 3; k++) begin
      rchk(idx[k], 32'hFFFFFFFF, 32'h0);
      apb(1'b1, idx[k], 8'hFF);
      rchk(idx[k], 32'hFFFFFFFF, msk[k]);
      apb(1'b1, idx[k], 8'h00);
    end
    apb(1'b1, `IDX_TX_INT_STATUS, 8'hFF);
    rchk(`IDX_TX_INT_STATUS, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, 8'h3B, 8'h55);
    chk(err, 1'b1);
    rchk(8'h3B, 32'hFFFFFFFF, 32'h0);
    chk(err, 1'b1);
  endtask
  task automatic t_events();
    int p;
    lock <= 1'b1;
    repeat (20) @(posedge clk);
    chk(pass, 1'b1);
    rchk(`IDX_TX_INT_STATUS, 32'h01, 32'h01);
    chk(irq, 1'b0);
    apb(1'b1, `IDX_TX_INT_ENABLE, 8'h1E);
    for (int j = 0; j < 3; j++) begin
      p = (j == 0) ? 1 : j + 2;
      {rxirq, slost, synced} <= 3'(1 << j);
      repeat (4) @(posedge clk);
      {rxirq, slost, synced} <= 3'b000;
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      rchk(`IDX_TX_INT_STATUS, 32'(1 << p), 32'(1 << p));
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
    end
  endtask
  task automatic t_cutoff();
    apb(1'b1, `IDX_RX_QUAL_CTRL, 8'h08);
    apb(1'b1, `IDX_RX_CUTOFF_CFG, 8'h01);
    frame(3, 4, 6, 99);
    chk(n_eof - e0, 0);
    chk(32'(n_byte - b0 >= 8 && n_byte - b0 <= 14), 1);
    rchk(`IDX_RX_STATUS, 32'h04, 32'h04);
    frame(3, 6, 6, 99);
    cnt(0, 0, 0);
    frame(3, 6, 6, 99);
    cnt(1, 1, 18);
    chk(n_sum - d0, 63);
    chk(n_rep, 1);
    apb(1'b1, `IDX_RX_CUTOFF_CFG, 8'h00);
  endtask
  task automatic t_qualify();
    apb(1'b1, `IDX_RX_QUAL_CTRL, 8'h06);
    frame(2, 4, 4, 99);
    chk(pass, 1'b0);
    frame(2, 4, 4, 99);
    chk(pass, 1'b1);
    chk(n_byte - b0, 0);
    frame(2, 4, 4, 99);
    cnt(1, 1, 8);
    chk(n_sum - d0, 20);
    apb(1'b1, `IDX_RX_QUAL_CTRL, 8'h15);
    frame(3, 4, 4, 99);
    chk(pass, 1'b0);
    frame(3, 4, 4, 99);
    chk(pass, 1'b1);
  endtask
  task automatic t_parity();
    apb(1'b1, `IDX_RX_QUAL_CTRL, 8'h26);
    apb(1'b1, `IDX_RX_CUTOFF_CFG, 8'h04);
    frame(3, 4, 4, 99);
    chk(pass, 1'b1);
    apb(1'b0, `IDX_TX_INT_STATUS, 8'h00);
    frame(3, 4, 4, 1);
    chk(pass, 1'b0);
    chk(32'(n_byte - b0 >= 4 && n_byte - b0 < 8 && n_eof == e0), 1);
    rchk(`IDX_TX_INT_STATUS, 32'h04, 32'h04);
    frame(3, 4, 4, 99);
    chk(pass, 1'b1);
    cnt(0, 0, 0);
    frame(3, 4, 4, 99);
    cnt(1, 1, 12);
    chk(n_sum - d0, 30);
    chk(n_rep, 2);
  endtask
  ////////////////////////////////////////
  // Main sequence: reset, then each scenario in turn.
  initial begin
    {clk, lclk, psel, penable, pwrite, lock, lframe, lline, perr} = 9'h000;
    {synced, slost, rxirq, rst} = 4'h1;
    paddr = 10'h000;
    pwdata = 32'h00000000;
    ldata = 8'h00;
    n_fail = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_events();
    t_cutoff();
    t_qualify();
    t_parity();
    end_of_test();
  end
endmodule
